// ===== include/abd_pkg.sv
package abd_pkg;
    // --------------------------------------------------------------
    // Band layout
    // --------------------------------------------------------------
    localparam int NBANDS = 9;
    localparam int BIN_SPAN = 4;
    localparam int EN_W = 24;
    localparam int SUM_W = 34;
    localparam int IDX_W = 9;
    localparam logic [IDX_W-1:0] BAND_KSTART [0:NBANDS-1] = '{9'd3, 9'd11, 9'd14, 9'd23, 9'd27,
                                                             9'd31, 9'd35, 9'd42, 9'd46};
    // DCT band edges in Hz, each 1500 Hz wide
    localparam logic [31:0] DCT_LO_HZ [0:NBANDS-1] = '{32'd1500, 32'd4500, 32'd6000, 32'd9000, 32'd10500,
                                                       32'd12000, 32'd13500, 32'd16500, 32'd18000};
    localparam logic [31:0] DCT_BAND_HZ = 32'd1500;
    localparam logic [31:0] DCT_POINTS_X2 = 32'd640;

    // --------------------------------------------------------------
    // Rates, bandwidth classes, log scaling (Q8 fixed point)
    // --------------------------------------------------------------
    typedef enum logic [1:0] {ABD_RATE_8K, ABD_RATE_16K, ABD_RATE_32K, ABD_RATE_48K} abd_rate_t;
    typedef enum logic [1:0] {ABD_BW_NARROW, ABD_BW_WIDE, ABD_BW_SUPER, ABD_BW_FULL} abd_bw_t;
    localparam logic [31:0] FS_HZ [0:3] = '{32'd8000, 32'd16000, 32'd32000, 32'd48000};
    localparam real FSCL [0:3] = '{88.293854, 88.300926, 88.304118, 88.028412};
    localparam int Q = 256;
    localparam int FB_DIV = 8;
    localparam logic signed [15:0] LOG_OFS [0:3] = '{
        16'(int'(($log10(real'(FB_DIV)) + 2.0 * $log10(FSCL[0])) * Q)),
        16'(int'(($log10(real'(FB_DIV)) + 2.0 * $log10(FSCL[1])) * Q)),
        16'(int'(($log10(real'(FB_DIV)) + 2.0 * $log10(FSCL[2])) * Q)),
        16'(int'(($log10(real'(FB_DIV)) + 2.0 * $log10(FSCL[3])) * Q))};
    localparam logic [15:0] LOG10_2_Q8 = 16'(int'(0.30103 * Q));
    localparam logic signed [15:0] CLASS_ADD = 16'(int'(1.6 * Q));
    localparam logic signed [15:0] NOISE_MIN_DB = 16'(30 * Q);

    // --------------------------------------------------------------
    // Counter limits and decision thresholds, per energy mode
    // --------------------------------------------------------------
    localparam logic [6:0] CNT_MIN = 7'd0;
    localparam logic [6:0] CNT_MAX = 7'd100;
    localparam logic [6:0] SEL_UP = 7'd90;
    localparam logic [6:0] SEL_DN = 7'd10;
    localparam logic signed [15:0] THR_INC [0:1][0:2] = '{'{16'sh00E6, 16'sh00B3, 16'sh0080},
                                                         '{16'sh0200, 16'sh01C0, 16'sh0180}};
    localparam logic signed [15:0] THR_DEC [0:1][0:2] = '{'{16'sh0066, 16'sh0040, 16'sh0033},
                                                         '{16'sh0180, 16'sh0140, 16'sh0100}};
    localparam logic signed [15:0] THR_GAP [0:1][0:2] = '{'{16'sh0400, 16'sh0400, 16'sh0400},
                                                         '{16'sh0400, 16'sh0400, 16'sh0400}};

    // --------------------------------------------------------------
    // Bitrate limits in units of 0.1 kbps
    // --------------------------------------------------------------
    localparam logic [10:0] BR_SUPER_MIN = 11'd96;
    localparam logic [10:0] BR_FULL_MIN = 11'd164;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AW-1:0] REG_COUNT = 8'h08;
    localparam logic [AW-1:0] REG_LTMEAN = 8'h0C;
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_DCT_BIT = 2;
    localparam int CTRL_BR_LSB = 8;
    localparam logic [1:0] CTRL_RATE_RST = 2'h1;
    localparam logic [10:0] CTRL_BR_RST = 11'h500;
endpackage

// ===== design/abd_detector.sv
// What this block does
// - Each aggregated band sums four consecutive 400 Hz bins, spanning 1600 Hz.
// - Nine bands use bins 3,11,14,23,27,31,35,42,46 onward, four each.
// - Filter-bank mode: log10 of band sum over eight times scale squared.
// - Scale factor chosen from the input sampling rate among four values.
// - Class means: narrow band 0, wide 1-2, super 3-6, full 7-8, plus 1.6.
// - Narrow max is narrow mean plus 1.6; others largest band plus 1.6.
// - DCT mode splits windowed DCT coefficients into nine 1.5 kHz bands.
// - DCT mode uses unscaled log10 and drops the 1.6 term.
// - Same decision logic for both modes, only thresholds differ.
// - Long-term narrow, wide, super means: 0.75 old plus 0.25 new.
// - Long-term update only with activity and noise above 30 dB.
// - Counter threshold tests run strictly one after another each frame.
// - Selection tests run in sequence; selections reset counters to 0 or 100.
// - Detected bandwidth is capped to widest class the bitrate supports.
// - Support: narrow 7.2-24.4, wide 7.2-128, super 9.6-128, full 16.4-128 kbps.
// - Reports one of four classes: narrow, wide, super-wide, full.
// - At 8 kHz input no detection runs; bandwidth is narrow.
// - Compatibility mode selects DCT energies, filter-bank energies otherwise.
`timescale 1ns/10ps
`default_nettype none
module abd_detector
    import abd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic bin_valid,
    input wire logic [IDX_W-1:0] bin_index,
    input wire logic [EN_W-1:0] bin_energy,
    input wire logic frame_end,
    input wire logic signal_activity_decision,
    input wire logic signed [15:0] noise_level_db,
    output logic busy,
    output logic [1:0] selected_bandwidth,
    output logic bw_valid
);
    typedef enum {ST_IDLE, ST_LOG, ST_CLASS, ST_COUNT, ST_SELECT, ST_DONE} abd_state_t;

    // ----------------------------------------------------------
    // Log10 in Q8 from leading-one position and 8 mantissa bits
    // ----------------------------------------------------------
    function automatic logic signed [15:0] abd_log10(input logic [SUM_W-1:0] x);
        int p;
        logic [SUM_W-1:0] n;
        logic [15:0] l2;
        logic [31:0] prod;
        p = 0;
        for (int i = 0; i < SUM_W; i++) begin
            if (x[i]) p = i;
        end
        n = x << (SUM_W - 1 - p);
        l2 = {8'(p), n[SUM_W-2 -: 8]};
        prod = 32'(l2) * 32'(LOG10_2_Q8);
        return signed'(prod[23:8]);
    endfunction

    function automatic logic [6:0] abd_sat(input logic [6:0] c, input logic up, input logic dn);
        logic [6:0] r;
        r = c;
        if (up && c < CNT_MAX) r = c + 7'd1;
        else if (dn && c > CNT_MIN) r = c - 7'd1;
        return r;
    endfunction

    abd_state_t state_reg;
    logic [SUM_W-1:0] sum_reg [0:NBANDS-1];
    logic signed [15:0] lg_reg [0:NBANDS-1];
    logic signed [15:0] mean_reg [0:3];
    logic signed [15:0] max_reg [0:3];
    logic signed [15:0] lt_reg [0:2];
    logic [6:0] cnt_reg [0:2];
    logic [3:0] step_reg;
    logic [1:0] bw_reg;
    logic [1:0] rate_reg;
    logic dct_reg;
    logic [10:0] br_reg;
    logic act_reg;
    logic [31:0] rdata_reg;

    // ----------------------------------------------------------
    // Register decode and read mux
    // ----------------------------------------------------------
    wire ctrl_wr = reg_wr && reg_addr == REG_CTRL;
    wire [31:0] ctrl_val = {13'h0, br_reg, 5'h0, dct_reg, rate_reg};
    wire [31:0] stat_val = {29'h0, busy, bw_reg};
    wire [31:0] cnt_val = {9'h0, cnt_reg[2], 1'b0, cnt_reg[1], 1'b0, cnt_reg[0]};
    wire [31:0] lt_val = {lt_reg[1], lt_reg[0]};
    wire [31:0] rd_mux = reg_addr == REG_CTRL ? ctrl_val :
                         reg_addr == REG_STATUS ? stat_val :
                         reg_addr == REG_COUNT ? cnt_val :
                         reg_addr == REG_LTMEAN ? lt_val : 32'h0000_0000;
    assign reg_rdata = rdata_reg;
    assign busy = state_reg != ST_IDLE;
    assign selected_bandwidth = bw_reg;

    // ----------------------------------------------------------
    // Bin to band membership for both energy modes
    // ----------------------------------------------------------
    logic [NBANDS-1:0] hit;
    logic [31:0] bin_hz;
    always_comb begin
        bin_hz = 32'(bin_index) * FS_HZ[rate_reg] / DCT_POINTS_X2;
        for (int b = 0; b < NBANDS; b++) begin
            if (dct_reg)
                hit[b] = bin_hz >= DCT_LO_HZ[b] && bin_hz < DCT_LO_HZ[b] + DCT_BAND_HZ;
            else
                hit[b] = bin_index >= BAND_KSTART[b] &&
                         bin_index < BAND_KSTART[b] + IDX_W'(BIN_SPAN);
        end
    end

    // ----------------------------------------------------------
    // Log value of the band under conversion
    // ----------------------------------------------------------
    wire [3:0] bi = step_reg;
    wire signed [15:0] lg_raw = abd_log10(sum_reg[bi]);
    wire signed [15:0] lg_val = dct_reg ? lg_raw : lg_raw - LOG_OFS[rate_reg];

    // ----------------------------------------------------------
    // Class means and maxima
    // ----------------------------------------------------------
    wire signed [15:0] add = dct_reg ? 16'sh0000 : CLASS_ADD;
    wire signed [17:0] s_wb = 18'(lg_reg[1]) + 18'(lg_reg[2]);
    wire signed [17:0] s_swb = 18'(lg_reg[3]) + 18'(lg_reg[4]) + 18'(lg_reg[5]) + 18'(lg_reg[6]);
    wire signed [17:0] s_fb = 18'(lg_reg[7]) + 18'(lg_reg[8]);
    wire signed [15:0] m_nb = lg_reg[0] + add;
    wire signed [15:0] m_wb = 16'(s_wb >>> 1) + add;
    wire signed [15:0] m_swb = 16'(s_swb >>> 2) + add;
    wire signed [15:0] m_fb = 16'(s_fb >>> 1) + add;
    wire signed [15:0] x_wb = lg_reg[1] > lg_reg[2] ? lg_reg[1] : lg_reg[2];
    wire signed [15:0] x_s1 = lg_reg[3] > lg_reg[4] ? lg_reg[3] : lg_reg[4];
    wire signed [15:0] x_s2 = lg_reg[5] > lg_reg[6] ? lg_reg[5] : lg_reg[6];
    wire signed [15:0] x_swb = x_s1 > x_s2 ? x_s1 : x_s2;
    wire signed [15:0] x_fb = lg_reg[7] > lg_reg[8] ? lg_reg[7] : lg_reg[8];
    wire lt_en = act_reg && noise_level_db > NOISE_MIN_DB;

    // ----------------------------------------------------------
    // One counter test per step, wide then super then full
    // ----------------------------------------------------------
    wire [1:0] ci = step_reg[1:0];
    wire signed [15:0] c_mean = mean_reg[ci + 2'd1];
    wire signed [15:0] c_max = max_reg[ci + 2'd1];
    wire signed [15:0] c_gap = lt_reg[ci] - c_mean;
    wire c_up = c_mean > THR_INC[dct_reg][ci] && c_gap < THR_GAP[dct_reg][ci];
    wire c_dn = c_max < THR_DEC[dct_reg][ci];

    // ----------------------------------------------------------
    // Sequential selection chain with counter resets
    // ----------------------------------------------------------
    logic [1:0] sel_bw;
    logic [6:0] sel_cnt [0:2];
    always_comb begin
        sel_bw = bw_reg;
        for (int k = 0; k < 3; k++) sel_cnt[k] = cnt_reg[k];
        if (sel_bw == ABD_BW_NARROW && sel_cnt[0] > SEL_UP) begin
            sel_bw = ABD_BW_WIDE;
            sel_cnt[0] = CNT_MAX;
        end
        if (sel_bw <= ABD_BW_WIDE && sel_cnt[1] > SEL_UP) begin
            sel_bw = ABD_BW_SUPER;
            sel_cnt[1] = CNT_MAX;
        end
        if (sel_bw <= ABD_BW_SUPER && sel_cnt[2] > SEL_UP) begin
            sel_bw = ABD_BW_FULL;
            sel_cnt[2] = CNT_MAX;
        end
        if (sel_bw == ABD_BW_FULL && sel_cnt[2] < SEL_DN) begin
            sel_bw = ABD_BW_SUPER;
            sel_cnt[2] = CNT_MIN;
        end
        if (sel_bw >= ABD_BW_SUPER && sel_cnt[1] < SEL_DN) begin
            sel_bw = ABD_BW_WIDE;
            sel_cnt[1] = CNT_MIN;
            sel_cnt[2] = CNT_MIN;
        end
        if (sel_bw >= ABD_BW_WIDE && sel_cnt[0] < SEL_DN) begin
            sel_bw = ABD_BW_NARROW;
            sel_cnt[0] = CNT_MIN;
        end
        if (rate_reg == ABD_RATE_8K) sel_bw = ABD_BW_NARROW;
    end

    // Bitrate cap: widest class each bitrate supports
    wire [1:0] cap_bw = br_reg >= BR_FULL_MIN ? ABD_BW_FULL :
                        br_reg >= BR_SUPER_MIN ? ABD_BW_SUPER : ABD_BW_WIDE;
    wire [1:0] out_bw = sel_bw > cap_bw ? cap_bw : sel_bw;

    // ----------------------------------------------------------
    // Control register and read data
    // ----------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rate_reg <= CTRL_RATE_RST;
            dct_reg <= 1'b0;
            br_reg <= CTRL_BR_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (ctrl_wr && !busy) begin
                rate_reg <= reg_wdata[CTRL_RATE_LSB +: 2];
                dct_reg <= reg_wdata[CTRL_DCT_BIT];
                br_reg <= reg_wdata[CTRL_BR_LSB +: 11];
            end
            rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------
    // Band accumulation, idle only
    // ----------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < NBANDS; b++) sum_reg[b] <= '0;
        end else if (state_reg == ST_DONE) begin
            for (int b = 0; b < NBANDS; b++) sum_reg[b] <= '0;
        end else if (state_reg == ST_IDLE && bin_valid) begin
            for (int b = 0; b < NBANDS; b++) begin
                if (hit[b]) sum_reg[b] <= sum_reg[b] + SUM_W'(bin_energy);
            end
        end
    end

    // ----------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            step_reg <= 4'h0;
            act_reg <= 1'b0;
            bw_reg <= ABD_BW_NARROW;
            bw_valid <= 1'b0;
            for (int b = 0; b < NBANDS; b++) lg_reg[b] <= '0;
            for (int c = 0; c < 4; c++) begin
                mean_reg[c] <= '0;
                max_reg[c] <= '0;
            end
            for (int k = 0; k < 3; k++) begin
                lt_reg[k] <= '0;
                cnt_reg[k] <= CNT_MIN;
            end
        end else begin
            bw_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    step_reg <= 4'h0;
                    if (frame_end) begin
                        act_reg <= signal_activity_decision;
                        state_reg <= rate_reg == ABD_RATE_8K ? ST_SELECT : ST_LOG;
                    end
                end
                ST_LOG: begin
                    lg_reg[bi] <= lg_val;
                    step_reg <= step_reg + 4'h1;
                    if (step_reg == 4'(NBANDS - 1)) state_reg <= ST_CLASS;
                end
                ST_CLASS: begin
                    mean_reg[0] <= m_nb;
                    mean_reg[1] <= m_wb;
                    mean_reg[2] <= m_swb;
                    mean_reg[3] <= m_fb;
                    max_reg[0] <= m_nb + add;
                    max_reg[1] <= x_wb + add;
                    max_reg[2] <= x_swb + add;
                    max_reg[3] <= x_fb + add;
                    if (lt_en) begin
                        lt_reg[0] <= 16'((18'sd3 * 18'(lt_reg[0]) + 18'(m_nb)) >>> 2);
                        lt_reg[1] <= 16'((18'sd3 * 18'(lt_reg[1]) + 18'(m_wb)) >>> 2);
                        lt_reg[2] <= 16'((18'sd3 * 18'(lt_reg[2]) + 18'(m_swb)) >>> 2);
                    end
                    step_reg <= 4'h0;
                    state_reg <= ST_COUNT;
                end
                ST_COUNT: begin
                    cnt_reg[ci] <= abd_sat(cnt_reg[ci], c_up, c_dn);
                    step_reg <= step_reg + 4'h1;
                    if (ci == 2'd2) state_reg <= ST_SELECT;
                end
                ST_SELECT: begin
                    for (int k = 0; k < 3; k++) cnt_reg[k] <= sel_cnt[k];
                    bw_reg <= out_bw;
                    bw_valid <= 1'b1;
                    state_reg <= ST_DONE;
                end
                ST_DONE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verif/abd_detector_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module abd_detector_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic frame_end,
    input wire logic busy,
    input wire logic [1:0] selected_bandwidth,
    input wire logic bw_valid
);
    // ----------------------------------------
    // Port timing checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(frame_end))
        else $error("busy rose without frame end");
    AST_BUSY_START: assert property (frame_end && !busy |=> busy)
        else $error("frame end did not start processing");
    AST_BW_LATENCY: assert property ($rose(busy) |-> (##1 bw_valid) or (##14 bw_valid))
        else $error("decision latency wrong");
    AST_BW_PULSE: assert property (bw_valid |=> !bw_valid)
        else $error("decision strobe longer than one cycle");
    AST_BUSY_TAIL: assert property (bw_valid |=> !busy)
        else $error("busy tail after decision wrong");
    AST_BW_HOLD: assert property (!bw_valid |-> $stable(selected_bandwidth))
        else $error("bandwidth changed without strobe");
    AST_BW_IN_BUSY: assert property (bw_valid |-> busy)
        else $error("decision strobe while idle");
endmodule

bind abd_detector abd_detector_assertions abd_detector_assertions_inst (
    .core_clk(core_clk),
    .rst(rst),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .frame_end(frame_end),
    .busy(busy),
    .selected_bandwidth(selected_bandwidth),
    .bw_valid(bw_valid)
);
`default_nettype wire

// ===== verif/abd_bin_source.sv
`timescale 1ns/10ps
`default_nettype none
module abd_bin_source
    import abd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic busy,
    input wire logic [EN_W-1:0] level,
    input wire logic [IDX_W-1:0] nbins,
    output logic bin_valid,
    output logic [IDX_W-1:0] bin_index,
    output logic [EN_W-1:0] bin_energy,
    output logic frame_end
);
    logic active_reg;
    logic [IDX_W-1:0] cnt_reg;

    // Streams bins 0 to nbins-1 one per cycle while idle, then ends the frame
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b0;
            cnt_reg <= '0;
            bin_valid <= 1'b0;
            frame_end <= 1'b0;
            bin_index <= '0;
            bin_energy <= '0;
        end else begin
            bin_valid <= 1'b0;
            frame_end <= 1'b0;
            bin_index <= ~bin_index; // Idle lines keep toggling
            bin_energy <= ~bin_energy;
            if (start && !active_reg) begin
                active_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (active_reg && !busy) begin
                if (cnt_reg < nbins) begin
                    bin_valid <= 1'b1;
                    bin_index <= cnt_reg;
                    bin_energy <= level;
                    cnt_reg <= cnt_reg + 1'b1;
                end else begin
                    frame_end <= 1'b1;
                    active_reg <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/abd_detector_test.sv
`timescale 1ns/10ps
`default_nettype none
module abd_detector_test
    import abd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, act = 1'b1, start = 1'b0;
    logic [AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, last_rd;
    logic signed [15:0] noise = 16'sh2800;
    logic [EN_W-1:0] level = 24'hff_ffff, bin_energy;
    logic [IDX_W-1:0] nbins = 9'h032, bin_index;
    logic bin_valid, frame_end, busy, bw_valid;
    logic [1:0] selected_bandwidth;
    logic gate_act [0:2] = '{1'b0, 1'b1, 1'b1};
    logic signed [15:0] gate_nz [0:2] = '{16'sh2800, 16'sh1e00, 16'sh1400};
    logic [10:0] cap_br [0:3] = '{11'h060, 11'h05f, 11'h0a4, 11'h0a3};
    logic [1:0] cap_bw [0:3] = '{ABD_BW_SUPER, ABD_BW_WIDE, ABD_BW_FULL, ABD_BW_SUPER};
    int error_cnt = 0, check_count = 0, cyc = 0;
    // Long-term mean after one update from zero at 16 kHz: a quarter of loud class mean, Q8
    localparam int LT_EXP = int'(0.25 * ($log10(4.0 * 16777215.0 / (real'(FB_DIV) * FSCL[1] * FSCL[1]))
                                         + 1.6) * Q);
    localparam int LT_TOL = 4;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    abd_detector abd_detector_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bin_valid(bin_valid), .bin_index(bin_index), .bin_energy(bin_energy), .frame_end(frame_end),
        .signal_activity_decision(act), .noise_level_db(noise), .busy(busy),
        .selected_bandwidth(selected_bandwidth), .bw_valid(bw_valid));
    abd_bin_source abd_bin_source_inst (.core_clk(core_clk), .rst(rst), .start(start), .busy(busy),
        .level(level), .nbins(nbins), .bin_valid(bin_valid), .bin_index(bin_index),
        .bin_energy(bin_energy), .frame_end(frame_end));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 last_rd = reg_rdata;
        chk(last_rd, exp, "register read");
    endtask

    // Read whose two signed halves must both lie near exp
    task automatic rd_near(input logic [AW-1:0] a, input int exp);
        int v;
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 last_rd = reg_rdata;
        for (int h = 0; h < 2; h++) begin
            v = int'(signed'(last_rd[16*h +: 16]));
            check_count++;
            if (v > exp + LT_TOL || v < exp - LT_TOL) begin
                error_cnt++;
                $display("mismatch at %0t: long-term mean %0d expected near %0d", $time, v, exp);
            end
        end
    endtask

    // One frame from the source; latency counted from the visible frame end
    task automatic frame(input logic [1:0] exp_bw, input int exp_lat, input logic on);
        int t0;
        t0 = -1;
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (400) begin
            #1;
            if (frame_end === 1'b1) t0 = cyc;
            if (bw_valid === 1'b1) break;
            @(posedge core_clk);
        end
        chk({31'h0, bw_valid}, 32'h0000_0001, "decision strobe");
        if (on) chk({30'h0, selected_bandwidth}, {30'h0, exp_bw}, "bandwidth");
        if (on) chk(cyc - t0, exp_lat, "latency");
    endtask

    task automatic frames(input int n, input logic [1:0] exp_bw);
        repeat (n - 1) frame(2'b00, 0, 1'b0);
        frame(exp_bw, 15, 1'b1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd(REG_CTRL, 32'h0005_0001);
        rd(REG_COUNT, 32'h0000_0000);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0000_0000);
        $display("test reset_values done");
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            act <= gate_act[i];
            noise <= gate_nz[i];
            frame(ABD_BW_NARROW, 15, 1'b1);
            rd(REG_LTMEAN, 32'h0000_0000);
        end
        @(posedge core_clk);
        act <= 1'b1;
        noise <= 16'sh2800;
        frame(ABD_BW_NARROW, 15, 1'b1);
        rd_near(REG_LTMEAN, LT_EXP);
        chk({31'h0, |last_rd[15:0] & |last_rd[31:16]}, 32'h1, "long-term update");
        $display("test long_term_gate done");
        wr(REG_CTRL, 32'h0005_0003);
        frames(100, ABD_BW_FULL);
        rd(REG_COUNT, 32'h0064_6464);
        $display("test loud_full done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, {13'h0000, cap_br[i], 6'h00, i[0] ? ABD_RATE_32K : ABD_RATE_48K});
            frame(cap_bw[i], 15, 1'b1);
        end
        wr(REG_CTRL, 32'h0005_0003);
        fork
            frame(ABD_BW_FULL, 15, 1'b1);
            begin
                wait (busy === 1'b1);
                wr(REG_CTRL, 32'h0000_0000);
            end
        join
        rd(REG_CTRL, 32'h0005_0003);
        $display("test bitrate_cap done");
        @(posedge core_clk);
        level <= 24'h00_0001;
        frames(100, ABD_BW_NARROW);
        rd(REG_COUNT, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000);
        $display("test silence done");
        wr(REG_CTRL, 32'h0005_0000);
        @(posedge core_clk);
        level <= 24'hff_ffff;
        frame(ABD_BW_NARROW, 2, 1'b1);
        $display("test rate_8k done");
        wr(REG_CTRL, 32'h0005_0007);
        @(posedge core_clk);
        nbins <= 9'h140;
        frames(100, ABD_BW_FULL);
        $display("test dct_mode done");
        close_out;
    end

    // Cuts a hang short well after the expected run length
    initial begin
        #900000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out;
    end
endmodule
`default_nettype wire
